/* sia_consts.svh */
// Purpose: offsets, field positions and reset values of the interrupt aggregator
// Assumes: register indices map to byte address index*4 on the bus
// Notes: definitions only
//
// Operation
// - summary bit 15 shows the power-state group
// - a summary bit reads 1 while its group is pending, else 0
// - summary bits 14, 13, 12 show thermal, general pin, button groups
// - summary bits 11, 8, 7 show watchdog, converter, power-path groups
// - summary bit 5 shows the clock and crystal group
// - summary bit 4 shows the programmable memory group
// - summary bits 1 and 0 show high-current and undervoltage groups
// - status bits 15 and 11 latch on rising source edges
// - status bits 12 and 1 latch on both source edges
// - status bits 8, 3, 2 latch on rising source edges
// - status bits 7..4 latch on the edge chosen by each direction bit
// - software clears a status bit by writing 1; writing 0 keeps it
`ifndef SIA_CONSTS_SVH
`define SIA_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is index times four)
// ----------------------------------------------------------------
`define SIA_IDX_SUMMARY 16'h4010
`define SIA_IDX_STATUS 16'h4011
`define SIA_IDX_MASK 16'h4020
`define SIA_IDX_DIRECTION 16'h4021

// ----------------------------------------------------------------
// summary field positions
// ----------------------------------------------------------------
`define SIA_SUM_POWER_STATE 15
`define SIA_SUM_THERMAL 14
`define SIA_SUM_GENERAL_PIN 13
`define SIA_SUM_BUTTON 12
`define SIA_SUM_WATCHDOG 11
`define SIA_SUM_CONVERTER 8
`define SIA_SUM_POWER_PATH 7
`define SIA_SUM_CLOCK 5
`define SIA_SUM_MEMORY 4
`define SIA_SUM_HIGH_CURRENT 1
`define SIA_SUM_UNDERVOLTAGE 0

// ----------------------------------------------------------------
// status field layout and edge classes
// ----------------------------------------------------------------
`define SIA_ST_LOW_SUPPLY 15
`define SIA_ST_BUTTON 12
`define SIA_ST_WATCHDOG 11
`define SIA_ST_DATA_READY 8
`define SIA_ST_CMP_LO 4
`define SIA_ST_CMP_HI 7
`define SIA_ST_PERIODIC 3
`define SIA_ST_ALARM 2
`define SIA_ST_THERMAL 1
`define SIA_STATUS_VALID 16'h99FE
`define SIA_EDGE_RISE 16'h890C
`define SIA_EDGE_BOTH 16'h1002

// ----------------------------------------------------------------
// reset values and bus responses
// ----------------------------------------------------------------
`define SIA_RST_STATUS 16'h0000
`define SIA_RST_MASK 16'h0000
`define SIA_RST_DIRECTION 4'h0
`define SIA_RESP_OKAY 2'h0
`define SIA_RESP_SLVERR 2'h2

`endif

/* sia_host.sv */
// Purpose: host bus master that services the aggregator registers
// Assumes: AXI4-Lite, one write and one read at a time
// Notes: waits without limit; the bench timeout ends a hang
`timescale 1ns/1ps
module sia_host (
   // clock
   input wire logic aclk,
   // write channels
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] awaddr,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   input wire logic bvalid,
   output logic bready,
   input wire logic [1:0] bresp,
   // read channels
   output logic arvalid,
   input wire logic arready,
   output logic [31:0] araddr,
   input wire logic rvalid,
   output logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, wdata, araddr} = 96'h0;
      wstrb = 4'h0;
   end

   task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= v;
      wstrb <= 4'hF;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
endmodule : sia_host

/* sia_pkg.sv */
// Purpose: types of the interrupt aggregator
// Assumes: constants come from sia_consts.svh
// Notes: the whole module state is one packed struct
package sia_pkg;

   typedef enum logic [0:0] {
      SIA_WR_COLLECT = 1'b0,
      SIA_WR_RESP = 1'b1
   } sia_wr_type;

   typedef enum logic [0:0] {
      SIA_RD_IDLE = 1'b0,
      SIA_RD_RESP = 1'b1
   } sia_rd_type;

   // raw event sources, asynchronous to aclk
   typedef struct packed {
      logic low_system_supply_threshold;
      logic button_level;
      logic watchdog_timeout;
      logic converter_data_ready;
      logic comparator_four;
      logic comparator_three;
      logic comparator_two;
      logic comparator_one;
      logic clock_periodic;
      logic clock_alarm;
      logic thermal_warning;
   } sia_events_type;

   // pending levels of groups whose flags live in other blocks
   typedef struct packed {
      logic power_state;
      logic thermal_other;
      logic general_pin;
      logic crystal;
      logic memory;
      logic high_current;
      logic undervoltage;
   } sia_groups_type;

   typedef struct packed {
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic [15:0] sync3;
      logic [15:0] level;
      logic [15:0] status;
      logic [15:0] mask;
      logic [3:0] direction;
      sia_wr_type wr;
      logic aw_held;
      logic [31:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      sia_rd_type rd;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic irq;
   } sia_state_type;

endpackage : sia_pkg

/* sia_props.sv */
// Purpose: concurrent checks on the aggregator ports
// Assumes: one clock, synchronous active-low reset
// Notes: bound to sia_top below
`timescale 1ns/1ps
`include "sia_consts.svh"
module sia_props
   import sia_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // group levels
   input wire sia_groups_type groups,
   // write channels
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   // read channels
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // interrupt
   input wire logic irq
);
   localparam logic [31:0] A_SUM = `SIA_IDX_SUMMARY * 4;
   localparam logic [31:0] A_ST = `SIA_IDX_STATUS * 4;
   localparam logic [31:0] A_MSK = `SIA_IDX_MASK * 4;
   localparam logic [31:0] A_DIR = `SIA_IDX_DIRECTION * 4;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic rd_sum;
   logic rd_st;
   logic rd_bad;
   assign rd_sum = arvalid && arready && araddr == A_SUM;
   assign rd_st = arvalid && arready && araddr == A_ST;
   assign rd_bad = arvalid && arready && !(araddr inside {A_SUM, A_ST, A_MSK, A_DIR});

   property p_rst; $rose(aresetn) |-> !irq && !rvalid && !bvalid; endproperty
   a_rst: assert property (p_rst) else $error("outputs busy after reset");
   property p_ps; rd_sum |=> rdata[15] == $past(groups.power_state); endproperty
   a_ps: assert property (p_ps) else $error("summary bit 15 wrong");
   property p_gp; rd_sum |=> rdata[13] == $past(groups.general_pin); endproperty
   a_gp: assert property (p_gp) else $error("summary bit 13 wrong");
   property p_low; rd_sum |=> rdata[4] == $past(groups.memory) && rdata[31:16] == 16'h0000;
   endproperty
   a_low: assert property (p_low) else $error("summary bit 4 wrong");
   property p_hc; rd_sum |=> rdata[1] == $past(groups.high_current); endproperty
   a_hc: assert property (p_hc) else $error("summary bit 1 wrong");
   property p_lay; rd_st |=> (rdata & ~{16'h0000, `SIA_STATUS_VALID}) == 32'h0; endproperty
   a_lay: assert property (p_lay) else $error("status reserved bit set");
   property p_rd_ans; arvalid && arready |=> rvalid && !arready; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_rd_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
   property p_wr; awvalid && awready && wvalid && wready |=> bvalid ##1 bvalid != $past(bready);
   endproperty
   a_wr: assert property (p_wr) else $error("write response wrong");
   property p_bad; rd_bad |=> rresp == `SIA_RESP_SLVERR && rdata == 32'h0; endproperty
   a_bad: assert property (p_bad) else $error("unmapped read not refused");
   c_st: cover property (rd_st);
   c_irq: cover property ($rose(irq));
   c_slv: cover property (bvalid && bresp == `SIA_RESP_SLVERR);
endmodule : sia_props

bind sia_top sia_props u_sia_props (.aclk(aclk), .aresetn(aresetn), .groups(groups),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
   .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
   .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));

/* sia_top.sv */
// Purpose: system interrupt aggregator with summary and latched status registers
// Assumes: AXI4-Lite slave on aclk; event sources are asynchronous levels
// Notes: one level interrupt output gated by the mask register
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sia_consts.svh"

module sia_top
   import sia_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // event sources and external group levels
   input sia_events_type events,
   input sia_groups_type groups,
   // write address channel
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic [2:0] awprot,
   // write data channel
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // write response channel
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // read address channel
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   input wire logic [2:0] arprot,
   // read data channel
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // interrupt
   output logic irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sia_state_type s_r;
   sia_state_type s_nxt;

   logic [15:0] source_vec;
   logic [15:0] level_nxt;
   logic [15:0] rise;
   logic [15:0] fall;
   logic [15:0] cmp_edge;
   logic [15:0] event_vec;
   logic [15:0] summary;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] lane_mask(input logic [3:0] strb);
      lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
   endfunction : lane_mask

   function automatic logic is_reg(input logic [31:0] addr, input logic [15:0] idx);
      is_reg = (addr[31:2] == {14'h0000, idx});
   endfunction : is_reg

   // ----------------------------------------------------------------
   // source mapping onto status bit positions
   // ----------------------------------------------------------------
   always_comb begin
      source_vec = 16'h0000;
      source_vec[`SIA_ST_LOW_SUPPLY] = events.low_system_supply_threshold;
      source_vec[`SIA_ST_BUTTON] = events.button_level;
      source_vec[`SIA_ST_WATCHDOG] = events.watchdog_timeout;
      source_vec[`SIA_ST_DATA_READY] = events.converter_data_ready;
      source_vec[`SIA_ST_CMP_HI] = events.comparator_four;
      source_vec[`SIA_ST_CMP_HI - 1] = events.comparator_three;
      source_vec[`SIA_ST_CMP_LO + 1] = events.comparator_two;
      source_vec[`SIA_ST_CMP_LO] = events.comparator_one;
      source_vec[`SIA_ST_PERIODIC] = events.clock_periodic;
      source_vec[`SIA_ST_ALARM] = events.clock_alarm;
      source_vec[`SIA_ST_THERMAL] = events.thermal_warning;
   end

   // ----------------------------------------------------------------
   // filtered level and edge detection
   // ----------------------------------------------------------------
   // a change counts once the second and third stages agree
   assign level_nxt = (s_r.sync2 & s_r.sync3) | (s_r.level & (s_r.sync2 ^ s_r.sync3));
   assign rise = level_nxt & ~s_r.level;
   assign fall = ~level_nxt & s_r.level;

   // per comparator: direction 1 latches the rising edge, 0 the falling edge
   genvar k;
   generate
      for (k = 0; k < 16; k++) begin : g_cmp
         if (k >= `SIA_ST_CMP_LO && k <= `SIA_ST_CMP_HI) begin : g_on
            assign cmp_edge[k] = s_r.direction[k - `SIA_ST_CMP_LO] ? rise[k] : fall[k];
         end else begin : g_off
            assign cmp_edge[k] = 1'b0;
         end
      end
   endgenerate

   assign event_vec = (rise & `SIA_EDGE_RISE)
      | ((rise | fall) & `SIA_EDGE_BOTH)
      | cmp_edge;

   // ----------------------------------------------------------------
   // summary register
   // ----------------------------------------------------------------
   always_comb begin
      summary = 16'h0000;
      summary[`SIA_SUM_POWER_STATE] = groups.power_state;
      summary[`SIA_SUM_THERMAL] = groups.thermal_other | s_r.status[`SIA_ST_THERMAL];
      summary[`SIA_SUM_GENERAL_PIN] = groups.general_pin;
      summary[`SIA_SUM_BUTTON] = s_r.status[`SIA_ST_BUTTON];
      summary[`SIA_SUM_WATCHDOG] = s_r.status[`SIA_ST_WATCHDOG];
      summary[`SIA_SUM_CONVERTER] =
         |s_r.status[`SIA_ST_DATA_READY:`SIA_ST_CMP_LO];
      summary[`SIA_SUM_POWER_PATH] = s_r.status[`SIA_ST_LOW_SUPPLY];
      summary[`SIA_SUM_CLOCK] = groups.crystal
         | s_r.status[`SIA_ST_PERIODIC] | s_r.status[`SIA_ST_ALARM];
      summary[`SIA_SUM_MEMORY] = groups.memory;
      summary[`SIA_SUM_HIGH_CURRENT] = groups.high_current;
      summary[`SIA_SUM_UNDERVOLTAGE] = groups.undervoltage;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [15:0] clr;
      logic [15:0] bm;
      clr = 16'h0000;
      bm = 16'h0000;
      s_nxt = s_r;

      s_nxt.sync1 = source_vec;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.sync3 = s_r.sync2;
      s_nxt.level = level_nxt;

      // write channel: address and data taken in either order
      case (s_r.wr)
         SIA_WR_COLLECT: begin
            if (awvalid && s_r.awready) begin
               s_nxt.aw_held = 1'b1;
               s_nxt.aw_addr = awaddr;
            end
            if (wvalid && s_r.wready) begin
               s_nxt.w_held = 1'b1;
               s_nxt.w_data = wdata;
               s_nxt.w_strb = wstrb;
            end
            if (s_nxt.aw_held && s_nxt.w_held) begin
               bm = lane_mask(s_nxt.w_strb);
               s_nxt.bresp = `SIA_RESP_OKAY;
               if (is_reg(s_nxt.aw_addr, `SIA_IDX_STATUS)) begin
                  clr = s_nxt.w_data[15:0] & bm;
               end else if (is_reg(s_nxt.aw_addr, `SIA_IDX_MASK)) begin
                  s_nxt.mask = ((s_r.mask & ~bm) | (s_nxt.w_data[15:0] & bm))
                     & `SIA_STATUS_VALID;
               end else if (is_reg(s_nxt.aw_addr, `SIA_IDX_DIRECTION)) begin
                  if (s_nxt.w_strb[0]) begin
                     s_nxt.direction = s_nxt.w_data[3:0];
                  end
               end else if (!is_reg(s_nxt.aw_addr, `SIA_IDX_SUMMARY)) begin
                  s_nxt.bresp = `SIA_RESP_SLVERR;
               end
               s_nxt.aw_held = 1'b0;
               s_nxt.w_held = 1'b0;
               s_nxt.bvalid = 1'b1;
               s_nxt.wr = SIA_WR_RESP;
            end
         end
         SIA_WR_RESP: begin
            if (bready) begin
               s_nxt.bvalid = 1'b0;
               s_nxt.wr = SIA_WR_COLLECT;
            end
         end
         default: begin
            s_nxt.bvalid = 1'b0;
            s_nxt.wr = SIA_WR_COLLECT;
         end
      endcase
      s_nxt.awready = (s_nxt.wr == SIA_WR_COLLECT) && !s_nxt.aw_held;
      s_nxt.wready = (s_nxt.wr == SIA_WR_COLLECT) && !s_nxt.w_held;

      // read channel
      case (s_r.rd)
         SIA_RD_IDLE: begin
            if (arvalid && s_r.arready) begin
               s_nxt.rvalid = 1'b1;
               s_nxt.rresp = `SIA_RESP_OKAY;
               s_nxt.rd = SIA_RD_RESP;
               if (is_reg(araddr, `SIA_IDX_SUMMARY)) begin
                  s_nxt.rdata = {16'h0000, summary};
               end else if (is_reg(araddr, `SIA_IDX_STATUS)) begin
                  s_nxt.rdata = {16'h0000, s_r.status};
               end else if (is_reg(araddr, `SIA_IDX_MASK)) begin
                  s_nxt.rdata = {16'h0000, s_r.mask};
               end else if (is_reg(araddr, `SIA_IDX_DIRECTION)) begin
                  s_nxt.rdata = {28'h0000000, s_r.direction};
               end else begin
                  s_nxt.rdata = 32'h00000000;
                  s_nxt.rresp = `SIA_RESP_SLVERR;
               end
            end
         end
         SIA_RD_RESP: begin
            if (rready) begin
               s_nxt.rvalid = 1'b0;
               s_nxt.rd = SIA_RD_IDLE;
            end
         end
         default: begin
            s_nxt.rvalid = 1'b0;
            s_nxt.rd = SIA_RD_IDLE;
         end
      endcase
      s_nxt.arready = (s_nxt.rd == SIA_RD_IDLE);

      // a new edge in the clearing cycle wins over the clear
      s_nxt.status = ((s_r.status & ~clr) | event_vec) & `SIA_STATUS_VALID;
      s_nxt.irq = |(s_nxt.status & s_nxt.mask);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.status <= `SIA_RST_STATUS;
         s_r.mask <= `SIA_RST_MASK;
         s_r.direction <= `SIA_RST_DIRECTION;
         s_r.wr <= SIA_WR_COLLECT;
         s_r.rd <= SIA_RD_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign awready = s_r.awready;
   assign wready = s_r.wready;
   assign bvalid = s_r.bvalid;
   assign bresp = s_r.bresp;
   assign arready = s_r.arready;
   assign rvalid = s_r.rvalid;
   assign rdata = s_r.rdata;
   assign rresp = s_r.rresp;
   assign irq = s_r.irq;

endmodule : sia_top

/* system_interrupt_aggregator_test.sv */
// Purpose: self-checking bench of the interrupt aggregator
// Assumes: sia_host drives the register bus
// Notes: one row per source, the four comparators sharing one row; hand tests after the loop
`timescale 1ns/1ps
`include "sia_consts.svh"
module system_interrupt_aggregator_test;
   import sia_pkg::*;
   typedef struct packed {logic [10:0] ev; logic [15:0] up; logic [15:0] dn;} sia_row_type;
   localparam logic [31:0] A_SUM = `SIA_IDX_SUMMARY * 4;
   localparam logic [31:0] A_ST = `SIA_IDX_STATUS * 4;
   localparam logic [31:0] A_MSK = `SIA_IDX_MASK * 4;
   localparam logic [31:0] A_DIR = `SIA_IDX_DIRECTION * 4;
   sia_row_type rows [8] = '{'{11'h400, 16'h8000, 16'h0000}, '{11'h200, 16'h1000, 16'h1000},
      '{11'h100, 16'h0800, 16'h0000}, '{11'h080, 16'h0100, 16'h0000},
      '{11'h078, 16'h0000, 16'h00F0}, '{11'h004, 16'h0008, 16'h0000},
      '{11'h002, 16'h0004, 16'h0000}, '{11'h001, 16'h0002, 16'h0002}};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   sia_events_type events = '0;
   sia_groups_type groups = '0;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
   logic [31:0] awaddr, wdata, araddr, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [15:0] g_exp = 16'h0000;
   logic mask_on = 1'b1;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;

   sia_top u_sia_top (.aclk(aclk), .aresetn(aresetn), .events(events), .groups(groups),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));
   sia_host u_sia_host (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

   initial forever #2.5 aclk = ~aclk;

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         $display("ERROR timeout expected done seen running");
         summarize();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   function automatic logic [15:0] sum_of(input logic [15:0] s);
      return {1'h0, s[1], 1'h0, s[12], s[11], 2'h0, |s[8:4], s[15], 1'h0, s[3] | s[2], 5'h00};
   endfunction : sum_of

   task automatic chk(input logic [15:0] st);
      u_sia_host.rd(A_ST, d, r);
      check("status", {16'h0000, st}, d);
      check("rresp", {30'h0, `SIA_RESP_OKAY}, {30'h0, r});
      u_sia_host.rd(A_SUM, d, r);
      check("summary", {16'h0000, sum_of(st) | g_exp}, d);
      check("irq", {31'h0, mask_on & (|st)}, {31'h0, irq});
   endtask : chk

   task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
      u_sia_host.wr(a, v, r);
      check("bresp", {30'h0, er}, {30'h0, r});
   endtask : wr

   task automatic settle(input logic [10:0] ev);
      @(posedge aclk) events <= ev;
      repeat (6) @(posedge aclk);
   endtask : settle

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      chk(16'h0000);
      wr(A_MSK, 32'h0000FFFF, `SIA_RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         settle(rows[i].ev);
         chk(rows[i].up);
         wr(A_ST, 32'h0000FFFF, `SIA_RESP_OKAY);
         settle(11'h000);
         chk(rows[i].dn);
         wr(A_ST, 32'h0000FFFF, `SIA_RESP_OKAY);
         $display("row %0d done", i);
      end
      wr(A_DIR, 32'h0000000F, `SIA_RESP_OKAY);
      settle(11'h078);
      chk(16'h00F0);
      wr(A_ST, 32'h0000FFFF, `SIA_RESP_OKAY);
      settle(11'h000);
      chk(16'h0000);
      $display("direction test done");
      settle(11'h500);
      wr(A_ST, 32'h00000000, `SIA_RESP_OKAY);
      chk(16'h8800);
      wr(A_ST, 32'h00000800, `SIA_RESP_OKAY);
      chk(16'h8000);
      wr(A_MSK, 32'h00000000, `SIA_RESP_OKAY);
      mask_on = 1'b0;
      chk(16'h8000);
      $display("clear and mask test done");
      groups <= 7'h7F;
      g_exp = 16'hE033;
      chk(16'h8000);
      groups <= 7'h00;
      g_exp = 16'h0000;
      chk(16'h8000);
      $display("group summary test done");
      u_sia_host.rd(A_ST + 32'h4, d, r);
      check("rresp", {30'h0, `SIA_RESP_SLVERR}, {30'h0, r});
      wr(A_ST + 32'h4, 32'h0000FFFF, `SIA_RESP_SLVERR);
      wr(A_SUM, 32'h0000FFFF, `SIA_RESP_OKAY);
      chk(16'h8000);
      $display("unmapped test done");
      settle(11'h000);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      chk(16'h0000);
      $display("reset test done");
      summarize();
   end
endmodule : system_interrupt_aggregator_test
